// ==== shared/mcvd_pkg.sv ====
package mcvd_pkg;

   // Configuration word widths.
   localparam int TX_CFG_W = 80;
   localparam int RX_CFG_W = 96;

   // Transmit configuration bit positions.
   localparam int TX_RESET_BIT = 0;
   localparam int TX_ENABLE_BIT = 1;
   localparam int TX_VLAN_BIT = 2;
   localparam int TX_FCS_BIT = 3;
   localparam int TX_JUMBO_BIT = 4;

   // Receive configuration field positions.
   localparam int RX_PAUSE_EN_BIT = 5;
   localparam int RX_ADDR_LSB = 32;
   localparam int RX_ADDR_MSB = 79;
   localparam int RX_PFC_EN_BIT = 80;
   localparam int RX_PRIO_LSB = 88;
   localparam int RX_PRIO_MSB = 95;

   // Frame size limits in bytes.
   localparam logic [15:0] MAX_LEN_PLAIN = 16'd1518;
   localparam logic [15:0] MAX_LEN_VLAN = 16'd1522;

   // Reset values.
   localparam logic [TX_CFG_W-1:0] TX_CFG_RST = '0;
   localparam logic [RX_CFG_W-1:0] RX_CFG_RST = '0;

   // One pause quantum is 512 bit times at 10 Gb/s, i.e. 51200 ps.
   localparam int QUANTUM_PS = 51200;
   localparam int CLK_PERIOD_PS = 25000;
   localparam int QUANTUM_CYC_RAW = QUANTUM_PS / CLK_PERIOD_PS;
   localparam int QUANTUM_CYC = (QUANTUM_CYC_RAW < 1) ? 1 : QUANTUM_CYC_RAW;

   localparam int NUM_PRIO = 8;
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [1:0] {
      MCVD_KIND_ORDINARY,
      MCVD_KIND_PAUSE,
      MCVD_KIND_PFC
   } mcvd_kind_t;

   // Summary of one received frame, produced by the receive parser.
   typedef struct packed {
      logic [47:0]          dest_addr;
      mcvd_kind_t           kind;
      logic                 error_free;
      logic [NUM_PRIO-1:0]  class_en;
      logic [NUM_PRIO-1:0][15:0] quanta;
   } mcvd_rx_frame_t;

   // Verdict handed back to the client receive stream.
   typedef struct packed {
      logic forward;
      logic bad;
   } mcvd_verdict_t;

   // Decoded transmit controls.
   typedef struct packed {
      logic        jumbo_en;
      logic        fcs_inband;
      logic        pad_fcs_en;
      logic        vlan_en;
      logic        operate;
      logic        block_reset;
      logic [15:0] max_len;
   } mcvd_tx_ctl_t;

endpackage

// ==== rtl/mcvd_top.sv ====

module mcvd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("mcvd_fifo: DEPTH must be a power of two of at least 2");
      end
   end

   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr_r];

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         count_r <= '0;
      end else if (push && !pop) begin
         count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
         count_r <= count_r - 1'b1;
      end
   end
endmodule

module mcvd_top #(
   parameter int FIFO_WORDS = mcvd_pkg::FIFO_DEPTH
) (
   input  wire logic                              sys_clk,
   input  wire logic                              rst,
   input  wire logic [mcvd_pkg::TX_CFG_W-1:0]     tx_cfg_vec,
   input  wire logic [mcvd_pkg::RX_CFG_W-1:0]     rx_cfg_vec,
   output mcvd_pkg::mcvd_tx_ctl_t                 tx_ctl,
   output logic                                   tx_pause_halt,
   output logic                                   rx_pfc_active,
   output logic [47:0]                            pause_match_addr,
   input  wire logic                              frame_valid,
   output logic                                   frame_ready,
   input  wire mcvd_pkg::mcvd_rx_frame_t          frame_info,
   output logic                                   verdict_valid,
   input  wire logic                              verdict_ready,
   output mcvd_pkg::mcvd_verdict_t                verdict,
   output logic                                   prio0_pause_valid,
   output logic                                   prio1_pause_valid,
   output logic                                   prio2_pause_valid,
   output logic                                   prio3_pause_valid,
   output logic                                   prio4_pause_valid,
   output logic                                   prio5_pause_valid,
   output logic                                   prio6_pause_valid,
   output logic                                   prio7_pause_valid
);
   import mcvd_pkg::*;

   localparam int FW = $bits(mcvd_rx_frame_t);
   localparam int QCW = $clog2(QUANTUM_CYC + 1);

   logic [TX_CFG_W-1:0] tx_cfg_r;
   logic [RX_CFG_W-1:0] rx_cfg_r;
   logic                q_valid;
   logic                q_ready;
   logic [FW-1:0]       q_bits;
   mcvd_rx_frame_t      q_frame;
   logic                addr_hit;
   logic                pfc_act;
   logic                pause_act;
   logic                verdict_hold_r;
   logic [NUM_PRIO-1:0] prio_en;
   logic [NUM_PRIO-1:0][15:0] prio_left_r;
   logic [NUM_PRIO-1:0] prio_valid_r;
   logic [15:0]         pause_left_r;
   logic [QCW-1:0]      quantum_cnt_r;
   logic                quantum_tick;

   initial begin
      if (FIFO_WORDS < 2) begin
         $error("mcvd_top: FIFO_WORDS must be at least 2");
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_cfg_r <= TX_CFG_RST;
         rx_cfg_r <= RX_CFG_RST;
      end else begin
         tx_cfg_r <= tx_cfg_vec;
         rx_cfg_r <= rx_cfg_vec;
      end
   end

   // Transmit controls are registered twice, so they change two cycles after the word.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_ctl <= '{block_reset: 1'b1, max_len: MAX_LEN_PLAIN, default: 1'b0};
      end else begin
         tx_ctl.jumbo_en    <= tx_cfg_r[TX_JUMBO_BIT];
         tx_ctl.fcs_inband  <= tx_cfg_r[TX_FCS_BIT];
         tx_ctl.pad_fcs_en  <= !tx_cfg_r[TX_FCS_BIT];
         tx_ctl.vlan_en     <= tx_cfg_r[TX_VLAN_BIT];
         tx_ctl.max_len     <= tx_cfg_r[TX_VLAN_BIT] ? MAX_LEN_VLAN : MAX_LEN_PLAIN;
         tx_ctl.operate     <= tx_cfg_r[TX_ENABLE_BIT] && !tx_cfg_r[TX_RESET_BIT];
         tx_ctl.block_reset <= tx_cfg_r[TX_RESET_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pause_match_addr <= '0;
         rx_pfc_active    <= 1'b0;
      end else begin
         // first line byte is the low byte
         pause_match_addr <= rx_cfg_r[RX_ADDR_MSB:RX_ADDR_LSB];
         rx_pfc_active    <= rx_cfg_r[RX_PFC_EN_BIT];
      end
   end

   mcvd_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_WORDS)
   ) u_frame_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (frame_valid),
      .in_ready  (frame_ready),
      .in_data   (frame_info),
      .out_valid (q_valid),
      .out_ready (q_ready),
      .out_data  (q_bits)
   );

   assign q_frame = mcvd_rx_frame_t'(q_bits);
   assign prio_en = rx_cfg_r[RX_PRIO_MSB:RX_PRIO_LSB];

   assign addr_hit = (q_frame.dest_addr == rx_cfg_r[RX_ADDR_MSB:RX_ADDR_LSB]);

   // One frame leaves the queue per verdict slot; a stalled client stalls the queue.
   assign q_ready = q_valid && (!verdict_hold_r || verdict_ready);

   // act on PFC only when enabled
   assign pfc_act = q_ready && rx_cfg_r[RX_PFC_EN_BIT] && q_frame.kind == MCVD_KIND_PFC
                    && q_frame.error_free && addr_hit;
   // pause frames halt transmit when enabled
   assign pause_act = q_ready && rx_cfg_r[RX_PAUSE_EN_BIT] && q_frame.kind == MCVD_KIND_PAUSE
                      && q_frame.error_free && addr_hit;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         verdict_hold_r <= 1'b0;
      end else if (q_ready) begin
         verdict_hold_r <= 1'b1;
      end else if (verdict_ready) begin
         verdict_hold_r <= 1'b0;
      end
   end

   assign verdict_valid = verdict_hold_r;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         verdict <= '0;
      end else if (q_ready) begin
         unique case (q_frame.kind)
            MCVD_KIND_PFC: begin
               verdict.forward <= 1'b1;
               verdict.bad     <= rx_cfg_r[RX_PFC_EN_BIT];
            end
            MCVD_KIND_PAUSE: begin
               verdict.forward <= !rx_cfg_r[RX_PAUSE_EN_BIT];
               verdict.bad     <= !q_frame.error_free;
            end
            MCVD_KIND_ORDINARY: begin
               verdict.forward <= 1'b1;
               verdict.bad     <= !q_frame.error_free;
            end
            default: begin
               verdict.forward <= 1'b1;
               verdict.bad     <= 1'b1;
            end
         endcase
      end
   end

   // Durations count in pause quanta; the prescaler rounds a quantum down to whole cycles.
   always_ff @(posedge sys_clk) begin
      if (rst || quantum_tick) begin
         quantum_cnt_r <= '0;
      end else begin
         quantum_cnt_r <= quantum_cnt_r + 1'b1;
      end
   end

   assign quantum_tick = (quantum_cnt_r == QCW'(QUANTUM_CYC - 1));

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prio_left_r <= '0;
      end else begin
         for (int p = 0; p < NUM_PRIO; p++) begin
            if (!prio_en[p]) begin
               prio_left_r[p] <= '0;
            end else if (pfc_act && q_frame.class_en[p]) begin
               prio_left_r[p] <= q_frame.quanta[p];
            end else if (quantum_tick && prio_left_r[p] != '0) begin
               prio_left_r[p] <= prio_left_r[p] - 1'b1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prio_valid_r <= '0;
      end else begin
         for (int p = 0; p < NUM_PRIO; p++) begin
            prio_valid_r[p] <= prio_en[p] && (prio_left_r[p] != '0);
         end
      end
   end

   assign prio0_pause_valid = prio_valid_r[0];
   assign prio1_pause_valid = prio_valid_r[1];
   assign prio2_pause_valid = prio_valid_r[2];
   assign prio3_pause_valid = prio_valid_r[3];
   assign prio4_pause_valid = prio_valid_r[4];
   assign prio5_pause_valid = prio_valid_r[5];
   assign prio6_pause_valid = prio_valid_r[6];
   assign prio7_pause_valid = prio_valid_r[7];

   always_ff @(posedge sys_clk) begin
      if (rst || !rx_cfg_r[RX_PAUSE_EN_BIT]) begin
         pause_left_r <= '0;
      end else if (pause_act) begin
         // a new pause frame restarts the halt
         pause_left_r <= q_frame.quanta[0];
      end else if (quantum_tick && pause_left_r != '0) begin
         pause_left_r <= pause_left_r - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_pause_halt <= 1'b0;
      end else begin
         tx_pause_halt <= (pause_left_r != '0);
      end
   end
endmodule

// ==== verification/mcvd_checker.sv ====
module mcvd_checker (
   input wire logic                       sys_clk,
   input wire logic                       rst,
   input wire logic [mcvd_pkg::TX_CFG_W-1:0] tx_cfg_vec,
   input wire logic [mcvd_pkg::RX_CFG_W-1:0] rx_cfg_vec,
   input wire mcvd_pkg::mcvd_tx_ctl_t     tx_ctl,
   input wire logic                       tx_pause_halt,
   input wire logic                       rx_pfc_active,
   input wire logic [47:0]                pause_match_addr,
   input wire logic                       frame_valid,
   input wire logic                       frame_ready,
   input wire logic                       verdict_valid,
   input wire logic                       verdict_ready,
   input wire mcvd_pkg::mcvd_verdict_t    verdict,
   input wire logic                       prio0_pause_valid,
   input wire logic                       prio1_pause_valid,
   input wire logic                       prio2_pause_valid,
   input wire logic                       prio3_pause_valid,
   input wire logic                       prio4_pause_valid,
   input wire logic                       prio5_pause_valid,
   input wire logic                       prio6_pause_valid,
   input wire logic                       prio7_pause_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   import mcvd_pkg::*;
   logic [2:0] settle_r;
   wire        ok = settle_r == 3'h7;
   wire [7:0]  en = rx_cfg_vec[RX_PRIO_MSB:RX_PRIO_LSB];
   wire [7:0]  pv = {prio7_pause_valid, prio6_pause_valid, prio5_pause_valid, prio4_pause_valid,
                     prio3_pause_valid, prio2_pause_valid, prio1_pause_valid, prio0_pause_valid};
   // The history taps below reach back into reset, so wait for the pipeline to refill.
   always_ff @(posedge sys_clk) begin
      if (rst) settle_r <= 3'h0;
      else if (!ok) settle_r <= settle_r + 3'h1;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   jumbo_a: assert property (ok |->
      tx_ctl.jumbo_en == $past(tx_cfg_vec[TX_JUMBO_BIT], 2))
      else $error("jumbo enable decode wrong");
   fcs_a: assert property (ok |-> tx_ctl.fcs_inband == $past(tx_cfg_vec[TX_FCS_BIT], 2)
      && tx_ctl.pad_fcs_en != tx_ctl.fcs_inband) else $error("fcs decode wrong");
   vlan_len_a: assert property (ok |-> tx_ctl.vlan_en == $past(tx_cfg_vec[TX_VLAN_BIT], 2)
      && tx_ctl.max_len == (tx_ctl.vlan_en ? MAX_LEN_VLAN : MAX_LEN_PLAIN))
      else $error("max len wrong");
   tx_enable_a: assert property (ok |-> tx_ctl.operate ==
      $past(tx_cfg_vec[TX_ENABLE_BIT] && !tx_cfg_vec[TX_RESET_BIT], 2)) else $error("operate wrong");
   tx_reset_a: assert property (ok |->
      tx_ctl.block_reset == $past(tx_cfg_vec[TX_RESET_BIT], 2))
      else $error("block reset wrong");
   pfc_flag_a: assert property (ok |->
      rx_pfc_active == $past(rx_cfg_vec[RX_PFC_EN_BIT], 2))
      else $error("pfc active wrong");
   match_addr_a: assert property (ok |->
      pause_match_addr == $past(rx_cfg_vec[RX_ADDR_MSB:RX_ADDR_LSB], 2))
      else $error("match address wrong");
   prio_off_a: assert property (ok |->
      (pv & ~($past(en, 2) | $past(en, 3) | $past(en, 4) | $past(en, 5))) == 8'h00)
      else $error("pause valid while priority disabled");
   halt_off_a: assert property (ok && !tx_pause_halt ##1 !rx_cfg_vec[RX_PAUSE_EN_BIT] [*4]
      |-> ##2 !tx_pause_halt [*2]) else $error("halt while pause disabled");
   verdict_hold_a: assert property (verdict_valid && !verdict_ready |=>
      verdict_valid && $stable(verdict)) else $error("verdict dropped before taken");
   cover property (pv == 8'hA5);
   cover property (frame_valid && !frame_ready);
   cover property (tx_pause_halt);
   cover property (verdict_valid && !verdict_ready);
endmodule
bind mcvd_top mcvd_checker chk (.*);

// ==== verification/mcvd_client.sv ====
module mcvd_client (
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic                    stall,
   output logic                         frame_valid,
   input  wire logic                    frame_ready,
   output mcvd_pkg::mcvd_rx_frame_t     frame_info,
   input  wire logic                    verdict_valid,
   output logic                         verdict_ready,
   input  wire mcvd_pkg::mcvd_verdict_t verdict
);
   timeunit 1ns;
   timeprecision 100ps;
   import mcvd_pkg::*;
   mcvd_rx_frame_t tx_q[$];
   mcvd_verdict_t  rx_q[$];
   initial begin
      frame_valid = 1'h0;
      frame_info = '0;
      verdict_ready = 1'h0;
   end
   // Clocked client side.
   // Idle frame lines invert every cycle, alternating between the last frame and its inverse, so stale data never passes as fresh.
   always @(posedge sys_clk) begin
      if (rst) begin
         frame_valid <= 1'h0;
         verdict_ready <= 1'h0;
      end else begin
         if (!frame_valid || frame_ready) begin
            frame_valid <= tx_q.size() != 0;
            frame_info <= (tx_q.size() != 0) ? tx_q.pop_front() : ~frame_info;
         end
         verdict_ready <= !stall;
         if (verdict_valid && verdict_ready) rx_q.push_back(verdict);
      end
   end
endmodule

// ==== verification/tb_top.sv ====
`define CHK(a, b) begin #1; compares++; if ((a) !== (b)) begin n_errors++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import mcvd_pkg::*;
   localparam logic [47:0] MADDR = 48'hFFEEDDCCBBAA;
   localparam logic [10:0] ROWS [8] = '{11'h008, 11'h08A, 11'h0C9, 11'h10C,
                                        11'h210, 11'h428, 11'h7B6, 11'h7F5};
   logic                sys_clk = 1'h0;
   logic                rst = 1'h1;
   logic                stall = 1'h0;
   logic [TX_CFG_W-1:0] tx_cfg_vec = '0;
   logic [RX_CFG_W-1:0] rx_cfg_vec = '0;
   logic [47:0]         pause_match_addr;
   mcvd_tx_ctl_t        tx_ctl;
   mcvd_rx_frame_t      frame_info;
   mcvd_verdict_t       verdict;
   logic tx_pause_halt, rx_pfc_active, frame_valid, frame_ready, verdict_valid, verdict_ready;
   logic prio0_pause_valid, prio1_pause_valid, prio2_pause_valid, prio3_pause_valid;
   logic prio4_pause_valid, prio5_pause_valid, prio6_pause_valid, prio7_pause_valid;
   int   n_errors = 0;
   int   compares = 0;
   int   cycles = 0;
   int   n;
   mcvd_verdict_t vd;
   wire [5:0] txb = {tx_ctl.jumbo_en, tx_ctl.fcs_inband, tx_ctl.pad_fcs_en, tx_ctl.vlan_en,
                     tx_ctl.operate, tx_ctl.block_reset};
   wire [7:0] pv = {prio7_pause_valid, prio6_pause_valid, prio5_pause_valid, prio4_pause_valid,
                    prio3_pause_valid, prio2_pause_valid, prio1_pause_valid, prio0_pause_valid};
   mcvd_top uut (.*);
   mcvd_client cli (.*);
   initial forever #12.5 sys_clk = ~sys_clk;
   function automatic logic [95:0] rxw(logic [7:0] pe, logic pfc, logic pause);
      return {pe, 7'h00, pfc, MADDR, 26'h0000000, pause, 5'h00};
   endfunction
   function automatic mcvd_rx_frame_t mk(mcvd_kind_t k, logic ef, logic [47:0] a,
         logic [7:0] c, logic [15:0] q);
      return {a, k, ef, c, {NUM_PRIO{q}}};
   endfunction
   task automatic cyc(int c);
      repeat (c) @(posedge sys_clk);
   endtask
   task automatic setrx(logic [95:0] v);
      cyc(1);
      rx_cfg_vec <= v;
      cyc(3);
   endtask
   task automatic snd(mcvd_rx_frame_t f, mcvd_verdict_t e);
      int w;
      w = 0;
      cli.tx_q.push_back(f);
      while (cli.rx_q.size() == 0 && w < 60) begin
         cyc(1);
         w++;
      end
      `CHK(w < 60, 1'h1)
      vd = cli.rx_q.pop_front();
      `CHK(vd, e)
   endtask
   task automatic complete_run;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_errors++;
         complete_run;
      end
   end
   initial begin
      cyc(2);
      rst <= 1'h0;
      `CHK({tx_ctl.block_reset, tx_ctl.max_len, pv}, {1'h1, MAX_LEN_PLAIN, 8'h00})
      foreach (ROWS[i]) begin
         cyc(1);
         tx_cfg_vec <= {75'h0, ROWS[i][10:6]};
         cyc(3);
         `CHK(txb, ROWS[i][5:0])
         `CHK(tx_ctl.max_len, ROWS[i][2] ? MAX_LEN_VLAN : MAX_LEN_PLAIN)
      end
      setrx(rxw(8'hFF, 1'h1, 1'h0));
      `CHK({rx_pfc_active, pause_match_addr}, {1'h1, MADDR})
      snd(mk(MCVD_KIND_PFC, 1'h1, MADDR, 8'hA5, 16'h0010), 2'h3);
      cyc(4);
      `CHK(pv, 8'hA5)
      snd(mk(MCVD_KIND_PFC, 1'h1, MADDR, 8'h01, 16'h0000), 2'h3);
      cyc(4);
      `CHK(pv, 8'hA4)
      snd(mk(MCVD_KIND_PFC, 1'h1, MADDR, 8'h80, 16'h0020), 2'h3);
      cyc(40);
      `CHK(pv, 8'h80)
      cyc(60);
      `CHK(pv, 8'h00)
      snd(mk(MCVD_KIND_PFC, 1'h1, ~MADDR, 8'hFF, 16'h0010), 2'h3);
      snd(mk(MCVD_KIND_PFC, 1'h0, MADDR, 8'hFF, 16'h0010), 2'h3);
      cyc(4);
      `CHK(pv, 8'h00)
      setrx(rxw(8'h0F, 1'h1, 1'h0));
      snd(mk(MCVD_KIND_PFC, 1'h1, MADDR, 8'hFF, 16'h0040), 2'h3);
      cyc(4);
      `CHK(pv, 8'h0F)
      setrx(rxw(8'h00, 1'h1, 1'h0));
      cyc(3);
      `CHK(pv, 8'h00)
      setrx(rxw(8'hFF, 1'h0, 1'h0));
      snd(mk(MCVD_KIND_PFC, 1'h1, MADDR, 8'hFF, 16'h0040), 2'h2);
      cyc(4);
      `CHK(pv, 8'h00)
      setrx(rxw(8'h00, 1'h0, 1'h1));
      snd(mk(MCVD_KIND_PAUSE, 1'h1, MADDR, 8'h00, 16'h0040), 2'h0);
      cyc(4);
      `CHK(tx_pause_halt, 1'h1)
      setrx(rxw(8'h00, 1'h0, 1'h0));
      cyc(3);
      `CHK(tx_pause_halt, 1'h0)
      snd(mk(MCVD_KIND_PAUSE, 1'h0, MADDR, 8'h00, 16'h0040), 2'h3);
      cyc(1);
      stall <= 1'h1;
      for (int i = 0; i < 20; i++) begin
         cli.tx_q.push_back(mk(MCVD_KIND_ORDINARY, i[0], ~MADDR, 8'h00, 16'h0000));
      end
      cyc(40);
      `CHK({frame_ready, verdict_valid}, 2'h1)
      cyc(1);
      stall <= 1'h0;
      n = 0;
      while (cli.rx_q.size() < 20 && n < 200) begin
         cyc(1);
         n++;
      end
      for (int i = 0; i < 20; i++) begin
         vd = cli.rx_q.pop_front();
         `CHK(vd, {1'h1, ~i[0]})
      end
      `CHK(frame_ready, 1'h1)
      complete_run;
   end
endmodule
